/* hdl/auto_restart_sequencer.v */
// trip auto-restart sequencer with avalon-mm register slave
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "restart_map.vh"
module auto_restart_sequencer #(
   parameter WORDS     = 6,
   parameter TICK_CLKS = `TICK_NS / `CLK_NS,
   parameter DS_TICKS  = `TENTH_NS / `TICK_NS
) (
   input  wire                clk,
   input  wire                nrst,
   // avalon-mm slave
   input  wire [7:0]          address,
   input  wire                read,
   input  wire                write,
   input  wire [31:0]         writedata,
   output reg  [31:0]         readdata,
   output reg                 waitrequest,
   // drive side
   input  wire [16*WORDS-1:0] trips,
   input  wire                error_active,
   input  wire                run_cmd,
   input  wire                ext_reset,
   output reg                 trip_reset,
   output reg                 pending,
   output reg                 restarting,
   output reg  [3:0]          attempts_left,
   output reg  [12:0]         time_left
);
   localparam S_IDLE  = 2'h0;
   localparam S_WAIT  = 2'h1;
   localparam S_COUNT = 2'h2;
   localparam S_LOCK  = 2'h3;

   reg                enable_r;
   reg [3:0]          attempts_r;
   reg [12:0]         init1_r;
   reg [12:0]         gap1_r;
   reg [12:0]         init2_r;
   reg [12:0]         gap2_r;
   wire [16*WORDS-1:0] sel1_all;
   wire [16*WORDS-1:0] sel2_all;
   reg [1:0]          state_r;
   reg                grp1_r;
   reg                first_r;
   reg [3:0]          done_r;
   reg [31:0]         ds_cnt_r;
   reg [15:0]         free_r;
   reg [31:0]         rd_nxt;
   reg [1:0]          state_nxt;
   wire               tick;
   wire               hit1;
   wire               hit2;
   wire               ds_tick;
   wire               acc;
   wire [12:0]        delay_sel;
   wire [15:0]        free_lim;
   wire [15:0]        four_gap;
   wire               wipe;
   wire               start;
   wire               fire;
   wire               free_done;
   wire [31:0]        rd_sel;
   wire [32*WORDS+31:0] rd_chain;

   exec_tick #(
      .PERIOD (TICK_CLKS)
   ) u_tick (
      .clk  (clk),
      .nrst (nrst),
      .tick (tick)
   );

   trip_match #(
      .WORDS (WORDS)
   ) u_match (
      .trips (trips),
      .sel1  (sel1_all),
      .sel2  (sel2_all),
      .hit1  (hit1),
      .hit2  (hit2)
   );

   // tenth-second strobe derived from execution ticks
   assign ds_tick = tick && (ds_cnt_r == DS_TICKS - 1);

   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         ds_cnt_r <= 32'h0;
      else if (ds_tick)
         ds_cnt_r <= 32'h0;
      else if (tick)
         ds_cnt_r <= ds_cnt_r + 32'h1;
   end

   // group one wins when a trip is selected in both groups
   assign delay_sel = grp1_r ? (first_r ? init1_r : gap1_r)
                             : (first_r ? init2_r : gap2_r);

   // trip-free window: longer of 5 minutes or four gaps
   assign four_gap = {1'b0, gap1_r, 2'b00};
   assign free_lim = (four_gap > `TRIP_FREE_DS) ? four_gap : 16'h0bb8;

   // avalon access: the first cycle of a request clears waitrequest and
   // latches read data; the second cycle is accepted and waitrequest rises
   // again at once, so back-to-back requests each see one wait cycle
   // reads have no side effects, so a repeated read is harmless
   assign acc = (read || write) && !waitrequest;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0;
      end else if (acc) begin
         waitrequest <= 1'b1;
      end else if (read || write) begin
         waitrequest <= 1'b0;
         readdata    <= rd_nxt;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // register read mux; the select words arrive through rd_sel
   // status word: tally, attempts left, pending, restarting, state code
   always @* begin
      rd_nxt = 32'h0;
      case (address)
         `REG_CTRL:      rd_nxt = {31'h0, enable_r};
         `REG_ATTEMPTS:  rd_nxt = {28'h0, attempts_r};
         `REG_INIT1:     rd_nxt = {19'h0, init1_r};
         `REG_GAP1:      rd_nxt = {19'h0, gap1_r};
         `REG_INIT2:     rd_nxt = {19'h0, init2_r};
         `REG_GAP2:      rd_nxt = {19'h0, gap2_r};
         `REG_STATUS:    rd_nxt = {20'h0, done_r, attempts_left, pending, restarting, state_r};
         `REG_TIME_LEFT: rd_nxt = {19'h0, time_left};
         default:        rd_nxt = rd_sel;
      endcase
   end

   // register writes, taken when waitrequest drops
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enable_r   <= 1'b0;
         attempts_r <= `ATTEMPTS_RST;
         init1_r    <= 13'h0;
         gap1_r     <= 13'h0;
         init2_r    <= 13'h0;
         gap2_r     <= 13'h0;
      end else if (write && acc) begin
         case (address)
            `REG_CTRL:     enable_r <= writedata[`CTRL_ENABLE_BIT];
            // out-of-range limits clamp, but an attempts write above 15 with a zero low nibble gives 1
            `REG_ATTEMPTS: attempts_r <= (writedata[3:0] < `ATTEMPTS_MIN) ? `ATTEMPTS_MIN :
                              (writedata[31:4] != 28'h0 || writedata[3:0] > `ATTEMPTS_MAX) ?
                              `ATTEMPTS_MAX : writedata[3:0];
            `REG_INIT1:    init1_r <= clamp(writedata);
            `REG_GAP1:     gap1_r  <= clamp(writedata);
            `REG_INIT2:    init2_r <= clamp(writedata);
            `REG_GAP2:     gap2_r  <= clamp(writedata);
            default: ;
         endcase
      end
   end

   // delays are held in tenths of a second, capped at 600.0 s
   function [12:0] clamp;
      input [31:0] v;
      begin
         clamp = (v > {19'h0, `DELAY_MAX_DS}) ? `DELAY_MAX_DS : v[12:0];
      end
   endfunction

   // select words: a pair of 16-bit registers per word index
   // the read path is an or-chain, so no wide indexed mux is built
   assign rd_chain[31:0] = 32'h0;

   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_sel
         reg  [15:0] word1_r;
         reg  [15:0] word2_r;
         wire        pick1;
         wire        pick2;

         assign pick1 = (address == `REG_SEL1_BASE + 4 * gi);
         assign pick2 = (address == `REG_SEL2_BASE + 4 * gi);

         // words reset to no trips selected
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               word1_r <= `SEL_RST;
               word2_r <= `SEL_RST;
            end else if (write && acc) begin
               if (pick1)
                  word1_r <= writedata[15:0];
               if (pick2)
                  word2_r <= writedata[15:0];
            end
         end

         assign sel1_all[16*gi +: 16] = word1_r;
         assign sel2_all[16*gi +: 16] = word2_r;
         assign rd_chain[32*gi+32 +: 32] = rd_chain[32*gi +: 32]
                                         | (pick1 ? {16'h0, word1_r} : 32'h0)
                                         | (pick2 ? {16'h0, word2_r} : 32'h0);
      end
   endgenerate

   assign rd_sel = rd_chain[32*WORDS +: 32];

   // sequence overview:
   //   idle  - watching for a selected trip while enabled and running
   //   wait  - trip seen, holding until every error condition is gone
   //   count - restart delay running in tenths of a second
   //   lock  - attempts used up, only a count clear releases it
   // the count clears on external reset, run removal or disable, and
   // after a long trip-free run; any clear also aborts a pending restart
   // delays step on a free-running tenth strobe, so an attempt may come up
   // to one tenth early; traded for one small shared counter
   // limitation: a trip still latched when a restart is issued starts the
   // next attempt as soon as the trip reset pulse has passed

   // count-clear conditions
   assign wipe = ext_reset || !run_cmd || !enable_r;

   // new sequence; the cycle in which trip_reset is high is skipped because the
   // drive clears its latched trips one edge later than our pulse
   assign start = run_cmd && enable_r && !trip_reset && (hit1 || hit2);

   // trip-free run long enough to forget earlier attempts
   assign free_done = (free_r >= free_lim);

   // restart issued when the delay has run out and errors stay clear
   assign fire = (state_r == S_COUNT) && (time_left == 13'h0) &&
                 !error_active && !wipe;

   // next state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (start) begin
               if (attempts_left == 4'h0)
                  state_nxt = S_LOCK;
               else
                  state_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            // timing starts only once all errors have cleared
            if (!error_active)
               state_nxt = S_COUNT;
         end
         S_COUNT: begin
            // a returning error restarts the wait rather than the drive
            if (error_active)
               state_nxt = S_WAIT;
            else if (time_left == 13'h0)
               state_nxt = S_IDLE;
         end
         S_LOCK: begin
            // held until a count clear, normally the external trip reset
            state_nxt = S_LOCK;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
      // any clear condition drops a scheduled restart
      if (wipe)
         state_nxt = S_IDLE;
   end

   // state register and the restart pulses
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r    <= S_IDLE;
         trip_reset <= 1'b0;
         restarting <= 1'b0;
         pending    <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         trip_reset <= fire;
         restarting <= fire;
         pending    <= (state_nxt == S_WAIT) || (state_nxt == S_COUNT);
      end
   end

   // delay group is taken when the sequence starts; group one wins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         grp1_r <= 1'b1;
      end else if (state_r == S_IDLE && state_nxt == S_WAIT) begin
         grp1_r <= hit1;
      end
   end

   // remaining time: loaded once, so later delay writes do not disturb a
   // running countdown; steps once per tenth and stops at zero
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         time_left <= 13'h0;
      end else if (state_r == S_WAIT && state_nxt == S_COUNT) begin
         time_left <= delay_sel;
      end else if (ds_tick && time_left != 13'h0) begin
         time_left <= time_left - 13'h1;
      end
   end

   // attempts left, issued-restart tally and first-attempt flag; a clear
   // and a restart never meet, since a restart needs wipe low and free_r is zero outside idle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         attempts_left <= `ATTEMPTS_RST;
         done_r        <= 4'h0;
         first_r       <= 1'b1;
      end else if (wipe || free_done) begin
         attempts_left <= attempts_r;
         done_r        <= 4'h0;
         first_r       <= 1'b1;
      end else if (fire) begin
         attempts_left <= attempts_left - 4'h1;
         done_r        <= done_r + 4'h1;
         first_r       <= 1'b0;
      end
   end

   // trip-free running time in tenths; any selected trip or stop restarts it
   // the limit is the longer of five minutes or four gaps, see free_lim
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         free_r <= 16'h0;
      end else if (state_r != S_IDLE || hit1 || hit2 || !run_cmd || free_done) begin
         free_r <= 16'h0;
      end else if (ds_tick) begin
         free_r <= free_r + 16'h1;
      end
   end
endmodule // auto_restart_sequencer
`default_nettype wire

/* hdl/exec_tick.v */
// execution-cycle tick generator
`timescale 1ns/1ps
`default_nettype none
module exec_tick #(
   parameter PERIOD = 10000
) (
   input  wire clk,
   input  wire nrst,
   output reg  tick
);
   reg [31:0] cnt_r;

   // free-running divider, one-cycle tick at wrap
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_r == PERIOD - 1) begin
         cnt_r <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule // exec_tick
`default_nettype wire

/* hdl/restart_map.vh */
// constants for the trip auto-restart sequencer
`ifndef RESTART_MAP_VH
`define RESTART_MAP_VH
// register byte offsets
`define REG_CTRL        8'h00
`define REG_ATTEMPTS    8'h04
`define REG_INIT1       8'h08
`define REG_GAP1        8'h0c
`define REG_INIT2       8'h10
`define REG_GAP2        8'h14
`define REG_STATUS      8'h18
`define REG_TIME_LEFT   8'h1c
`define REG_SEL1_BASE   8'h20
`define REG_SEL2_BASE   8'h38
// field positions and reset values
`define CTRL_ENABLE_BIT 0
`define ATTEMPTS_RST    4'h5
`define ATTEMPTS_MIN    4'h1
`define ATTEMPTS_MAX    4'ha
`define DELAY_MAX_DS    13'h1770
`define SEL_RST         16'h0000
// execution tick of 100 us, time counted in tenths of a second
`define TICK_NS         100000
`define CLK_NS          10
`define TENTH_NS        100000000
`define TRIP_FREE_DS    3000
`endif

/* hdl/trip_match.v */
// trip selection matcher for both trigger groups
`timescale 1ns/1ps
`default_nettype none
module trip_match #(
   parameter WORDS = 6
) (
   input  wire [16*WORDS-1:0] trips,
   input  wire [16*WORDS-1:0] sel1,
   input  wire [16*WORDS-1:0] sel2,
   output wire                hit1,
   output wire                hit2
);
   // a set select bit enables restart for that trip
   assign hit1 = |(trips & sel1);
   assign hit2 = |(trips & sel2);
endmodule // trip_match
`default_nettype wire

/* testbench/auto_restart_sequencer_tb.sv */
// self-checking bench for the trip auto-restart sequencer
`timescale 1ns/1ps
`default_nettype none
`include "restart_map.vh"
module auto_restart_sequencer_tb;
   logic        clk, nrst, read, write, run_cmd, ext_reset, fire;
   logic [7:0]  address;
   logic [31:0] writedata, rd;
   logic [6:0]  idx;
   wire  [31:0] readdata;
   wire         waitrequest, trip_reset, pending, restarting, error_active;
   wire  [3:0]  attempts_left;
   wire  [12:0] time_left;
   wire  [95:0] trips;
   int          error_cnt, cmp_count;
   // short tick and tenth-second counts: one tenth is four clocks
   auto_restart_sequencer #(.WORDS(6), .TICK_CLKS(2), .DS_TICKS(2)) dut (.clk(clk),
      .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .trips(trips),
      .error_active(error_active), .run_cmd(run_cmd), .ext_reset(ext_reset),
      .trip_reset(trip_reset), .pending(pending), .restarting(restarting),
      .attempts_left(attempts_left), .time_left(time_left));
   drive_model fault (.clk(clk), .nrst(nrst), .fire(fire), .idx(idx), .clr(ext_reset),
      .trip_reset(trip_reset), .trips(trips), .error_active(error_active));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hold the request until waitrequest is seen low, then release
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ext_pulse();
      ext_reset <= 1'b1;
      @(posedge clk);
      ext_reset <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // raise a trip, let the error clear, time the restart from that moment
   task automatic trip(input logic [6:0] b, input int ds, input logic go, input logic [3:0] left);
      int n;
      n = 1;
      idx <= b;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      while (error_active !== 1'b0) @(posedge clk);
      chk(pending, go);
      @(posedge clk);
      if (go) chk(time_left, ds);
      while (restarting !== 1'b1 && n < ds * 4 + 12) begin
         @(posedge clk);
         n++;
      end
      chk(restarting, go);
      if (go) chk(n >= ds * 4 - 1 && n <= ds * 4 + 3, 1);
      repeat (3) @(posedge clk);
      chk(attempts_left, left);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the whole run takes well under two thousand cycles
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
   initial begin
      {nrst, read, write, run_cmd, ext_reset, fire} = 6'h0;
      {address, writedata, idx} = 47'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(attempts_left, `ATTEMPTS_RST);
      bus(0, `REG_ATTEMPTS, 0); chk(rd[3:0], `ATTEMPTS_RST);
      bus(0, `REG_CTRL, 0); chk(rd[0], 1'b0);
      bus(0, `REG_SEL2_BASE + 8'h14, 0); chk(rd[15:0], `SEL_RST);
      bus(0, 8'hfc, 0);
      bus(1, `REG_SEL1_BASE, 32'h1);
      bus(1, `REG_SEL1_BASE + 8'h4, 32'h2);
      bus(1, `REG_SEL2_BASE + 8'h4, 32'h3);
      bus(1, `REG_INIT1, 3);
      bus(1, `REG_GAP1, 2);
      bus(1, `REG_INIT2, 6);
      bus(1, `REG_GAP2, 5);
      bus(1, `REG_ATTEMPTS, 3);
      run_cmd <= 1'b1;
      trip(0, 0, 0, 4'h3);
      ext_pulse();
      bus(1, `REG_CTRL, 1);
      trip(0, 3, 1, 4'h2);
      trip(0, 2, 1, 4'h1);
      trip(0, 2, 1, 4'h0);
      trip(0, 2, 0, 4'h0);
      ext_pulse();
      chk(attempts_left, 4'h3);
      trip(16, 6, 1, 4'h2);
      trip(17, 2, 1, 4'h1);
      run_cmd <= 1'b0;
      repeat (8) @(posedge clk);
      chk(attempts_left, 4'h3);
      summarize();
   end
endmodule // auto_restart_sequencer_tb
`default_nettype wire

/* testbench/drive_model.sv */
// behavioural drive trip logic facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        fire,
   input  wire logic [6:0]  idx,
   input  wire logic        clr,
   input  wire logic        trip_reset,
   output var  logic [95:0] trips,
   output wire logic        error_active
);
   logic [3:0] hold_r;
   // the trip latches until reset, but the error itself clears after a fixed hold
   assign error_active = hold_r != 4'h0;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trips  <= 96'h0;
         hold_r <= 4'h0;
      end else begin
         if (trip_reset || clr) trips <= 96'h0;
         if (fire) trips[idx] <= 1'b1;
         if (fire) hold_r <= 4'ha;
         else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
      end
   end
endmodule // drive_model
`default_nettype wire

/* testbench/restart_asserts.sv */
// port checks for the trip auto-restart sequencer
`timescale 1ns/1ps
`default_nettype none
module restart_asserts (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        error_active,
   input wire logic        trip_reset,
   input wire logic        pending,
   input wire logic        restarting,
   input wire logic [3:0]  attempts_left,
   input wire logic [12:0] time_left
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   one_cycle_pulse_a: assert property (restarting |=> !restarting)
      else $error("restart pulse too long");
   limit_range_a: assert property (attempts_left <= 4'ha)
      else $error("attempts above limit");
   none_at_zero_a: assert property (restarting |-> $past(attempts_left) != 4'h0)
      else $error("restart with no attempts");
   step_down_a: assert property (restarting |->
      attempts_left == $past(attempts_left) - 4'h1)
      else $error("attempts dropped by more than one");
   error_blocks_a: assert property (error_active |-> !restarting)
      else $error("restart while error active");
   pending_first_a: assert property (restarting |-> $past(pending))
      else $error("restart without pending");
   countdown_step_a: assert property ($past(time_left) != 13'h0 && time_left < $past(time_left)
      |-> time_left == $past(time_left) - 13'h1)
      else $error("countdown skipped");
   delay_bound_a: assert property (time_left <= 13'h1770)
      else $error("time left above maximum");
   trip_cleared_a: assert property (restarting |-> trip_reset)
      else $error("restart without trip reset");
endmodule // restart_asserts
bind auto_restart_sequencer restart_asserts chk (.clk(clk), .nrst(nrst),
   .error_active(error_active), .trip_reset(trip_reset), .pending(pending),
   .restarting(restarting), .attempts_left(attempts_left), .time_left(time_left));
`default_nettype wire
